// ==== src/bec_pkg.sv ====
package bec_pkg;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] BUS_FAULT_OFS = 12'h040;
  localparam logic [11:0] NODE_CONFIG_OFS = 12'h080;
  localparam logic [3:0] FULL_WORD_BE = 4'hf;

  // ****************************************************************
  // Bus fault register fields
  // ****************************************************************
  localparam int FLAG_W = 18;
  localparam int LOCAL_SUMMARY_BIT = 18;
  localparam int CTL_DRIVE_BIT = 17;
  localparam int DATA_DRIVE_BIT = 16;
  localparam int MODIFIED_BIT = 15;
  localparam int COPY_HELD_BIT = 14;
  localparam int CMD_STROBE_BIT = 13;
  localparam int MISSING_CONFIRM_BIT = 12;
  localparam int UNEXP_CONFIRM_BIT = 11;
  localparam int HOLD_OFF_BIT = 10;
  localparam int DRIVING_FAULT_BIT = 9;
  localparam int REG_PARITY2_BIT = 8;
  localparam int REG_PARITY_BIT = 7;
  localparam int CMD_PARITY2_BIT = 6;
  localparam int CMD_PARITY_BIT = 5;
  localparam int CORR2_BIT = 4;
  localparam int CORR_BIT = 3;
  localparam int UNCORR2_BIT = 2;
  localparam int UNCORR_BIT = 1;
  localparam int FAULT_SEEN_BIT = 0;
  localparam logic [17:0] FLAGS_RESET = 18'h00000;
  // Flags whose being set keeps the shared fault line driven
  localparam logic [17:0] FAULT_LINE_MASK = 18'h3feaa;
  // First-error flags that lock the captured command bits
  localparam logic [17:0] CAPTURE_MASK = 18'h000aa;
  localparam int CMD_W = 39;

  // ****************************************************************
  // Node configuration register fields
  // ****************************************************************
  localparam int SELFTEST_BIT = 31;
  localparam int REINIT_BIT = 30;
  localparam int HALT_BIT = 29;
  localparam int JOIN_BIT = 28;
  localparam int ZERO_HI_BIT = 27;
  localparam int ZERO_LO_BIT = 1;
  localparam int CORR_EN_BIT = 0;
  localparam int ZERO_W = 27;
  localparam logic SELFTEST_RESET = 1'b1;
  localparam logic HALT_RESET = 1'b0;
  localparam logic JOIN_RESET = 1'b0;
  localparam logic [26:0] ZERO_RESET = 27'h0000000;
  localparam logic CORR_EN_RESET = 1'b0;

endpackage

// ==== src/bec_regs.sv ====
`timescale 1ns/1ps
module bec_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [bec_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ctl_drive_err,
  input wire logic data_drive_err,
  input wire logic modified_signal_err,
  input wire logic copy_held_err,
  input wire logic command_strobe_err,
  input wire logic missing_confirm_err,
  input wire logic unexpected_confirm_err,
  input wire logic hold_off_err,
  input wire logic correctable_err,
  input wire logic uncorrectable_err,
  input wire logic command_parity_err,
  input wire logic register_parity_err,
  input wire logic driving_data,
  input wire logic [bec_pkg::CMD_W-1:0] command_bits,
  input wire logic module_fault,
  input wire logic bus_fault_in,
  input wire logic selftest_done,
  input wire logic bus_reset_cmd,
  output logic bus_fault_out,
  output logic [bec_pkg::CMD_W-1:0] captured_command,
  output logic console_mode,
  output logic node_reinit,
  output logic correctable_detect_on
);
  import bec_pkg::*;

  // ****************************************************************
  // Avalon slave
  // ****************************************************************
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic bus_fire;
  logic wr_fire;
  logic hit_fault;
  logic hit_config;

  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;
  logic summary_reg;
  logic summary_next;
  logic fault_out_reg;
  logic fault_out_next;
  logic [CMD_W-1:0] capture_reg;
  logic [CMD_W-1:0] capture_next;
  logic meta_reg;
  logic sync_reg;

  logic selftest_reg;
  logic selftest_next;
  logic halt_reg;
  logic halt_next;
  logic join_reg;
  logic join_next;
  logic [ZERO_W-1:0] zero_field_reg;
  logic [ZERO_W-1:0] zero_field_next;
  logic corr_en_reg;
  logic corr_en_next;
  logic reinit_reg;
  logic reinit_next;
  logic console_reg;
  logic console_next;

  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic corr_seen;
  logic wr_fault;
  logic wr_config;

  // A request is answered one cycle after it is first seen
  assign bus_fire = (avs_read | avs_write) & ~wait_reg;
  assign hit_fault = (avs_address == BUS_FAULT_OFS);
  assign hit_config = (avs_address == NODE_CONFIG_OFS);
  // Partial writes are acknowledged but dropped
  // full word only
  assign wr_fire = avs_write & bus_fire & (avs_byteenable == FULL_WORD_BE);
  assign wr_fault = wr_fire & hit_fault;
  assign wr_config = wr_fire & hit_config;

  always_comb begin
    wait_next = ~((avs_read | avs_write) & wait_reg);
    rdata_next = rdata_reg;
    if (avs_read & wait_reg) begin
      if (hit_fault) begin
        rdata_next = {13'h0000, summary_reg, flags_reg};
      end else if (hit_config) begin
        // Reinit trigger is write-only and reads zero
        rdata_next = {selftest_reg, 1'b0, halt_reg, join_reg, zero_field_reg, corr_en_reg};
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Fault flags
  // ****************************************************************
  // gated detection
  assign corr_seen = correctable_err & corr_en_reg;

  always_comb begin
    flag_set = FLAGS_RESET;
    flag_set[CTL_DRIVE_BIT] = ctl_drive_err;
    flag_set[DATA_DRIVE_BIT] = data_drive_err;
    flag_set[MODIFIED_BIT] = modified_signal_err;
    flag_set[COPY_HELD_BIT] = copy_held_err;
    flag_set[CMD_STROBE_BIT] = command_strobe_err;
    flag_set[MISSING_CONFIRM_BIT] = missing_confirm_err;
    flag_set[UNEXP_CONFIRM_BIT] = unexpected_confirm_err;
    flag_set[HOLD_OFF_BIT] = hold_off_err;
    flag_set[DRIVING_FAULT_BIT] = driving_data &
        (corr_seen | uncorrectable_err | command_parity_err | register_parity_err);
    flag_set[REG_PARITY_BIT] = register_parity_err & ~flags_reg[REG_PARITY_BIT];
    flag_set[REG_PARITY2_BIT] = register_parity_err & flags_reg[REG_PARITY_BIT];
    flag_set[CMD_PARITY_BIT] = command_parity_err & ~flags_reg[CMD_PARITY_BIT];
    flag_set[CMD_PARITY2_BIT] = command_parity_err & flags_reg[CMD_PARITY_BIT];
    flag_set[CORR_BIT] = corr_seen & ~flags_reg[CORR_BIT];
    flag_set[CORR2_BIT] = corr_seen & flags_reg[CORR_BIT];
    flag_set[UNCORR_BIT] = uncorrectable_err & ~flags_reg[UNCORR_BIT];
    flag_set[UNCORR2_BIT] = uncorrectable_err & flags_reg[UNCORR_BIT];
    flag_set[FAULT_SEEN_BIT] = sync_reg;
  end

  always_comb begin
    // bit 18 and reserved bits ignore writes
    flag_clr = wr_fault ? avs_writedata[FLAG_W-1:0] : FLAGS_RESET;
    if (bus_reset_cmd) begin
      flags_next = flag_set;
    end else begin
      flags_next = (flags_reg & ~flag_clr) | flag_set;
    end
    summary_next = module_fault;
    fault_out_next = |(flags_next & FAULT_LINE_MASK);
    capture_next = capture_reg;
    // Only the first of the data errors locks the command bits
    if (|(flag_set & CAPTURE_MASK) && !(|(flags_reg & CAPTURE_MASK))) begin
      capture_next = command_bits;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= FLAGS_RESET;
      summary_reg <= 1'b0;
      fault_out_reg <= 1'b0;
      capture_reg <= '0;
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      summary_reg <= summary_next;
      fault_out_reg <= fault_out_next;
      capture_reg <= capture_next;
      meta_reg <= bus_fault_in;
      sync_reg <= meta_reg;
    end
  end

  // ****************************************************************
  // Node configuration
  // ****************************************************************
  always_comb begin
    selftest_next = selftest_reg;
    halt_next = halt_reg;
    zero_field_next = zero_field_reg;
    corr_en_next = corr_en_reg;
    if (selftest_done || (wr_config && avs_writedata[SELFTEST_BIT])) begin
      selftest_next = 1'b0;
    end
    if (wr_config) begin
      halt_next = avs_writedata[HALT_BIT];
      // field stored as written; software keeps it zero
      zero_field_next = avs_writedata[ZERO_HI_BIT:ZERO_LO_BIT];
      corr_en_next = avs_writedata[CORR_EN_BIT];
    end
    reinit_next = wr_config & avs_writedata[REINIT_BIT];
    join_next = join_reg;
    if (bus_reset_cmd || (wr_config && avs_writedata[JOIN_BIT])) begin
      join_next = 1'b0;
    end
    if (reinit_next) begin
      join_next = 1'b1;
    end
    if (bus_reset_cmd) begin
      selftest_next = SELFTEST_RESET;
      halt_next = HALT_RESET;
      zero_field_next = ZERO_RESET;
      corr_en_next = CORR_EN_RESET;
    end
    console_next = halt_next | reinit_next;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      selftest_reg <= SELFTEST_RESET;
      halt_reg <= HALT_RESET;
      join_reg <= JOIN_RESET;
      zero_field_reg <= ZERO_RESET;
      corr_en_reg <= CORR_EN_RESET;
      reinit_reg <= 1'b0;
      console_reg <= 1'b0;
    end else begin
      selftest_reg <= selftest_next;
      halt_reg <= halt_next;
      join_reg <= join_next;
      zero_field_reg <= zero_field_next;
      corr_en_reg <= corr_en_next;
      reinit_reg <= reinit_next;
      console_reg <= console_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign bus_fault_out = fault_out_reg;
  assign captured_command = capture_reg;
  assign console_mode = console_reg;
  assign node_reinit = reinit_reg;
  assign correctable_detect_on = corr_en_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [FLAG_W-1:0] keep_mask;
  assign keep_mask = bus_reset_cmd ? FLAGS_RESET : (flags_reg & ~flag_clr);

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  flag_latch_a: assert property (1'b1 |=>
      ((flags_reg & $past(keep_mask)) == $past(keep_mask)))
    else $error("fault flag dropped without clear");
  summary_follow_a: assert property (module_fault |=> summary_reg ##1 1'b1)
    else $error("local summary not set");
  ctl_fault_a: assert property (ctl_drive_err |=>
      flags_reg[CTL_DRIVE_BIT] && bus_fault_out)
    else $error("control drive fault not raised");
  data_fault_a: assert property (data_drive_err |=>
      flags_reg[DATA_DRIVE_BIT] && bus_fault_out)
    else $error("data drive fault not raised");
  modified_viol_a: assert property (modified_signal_err |=>
      flags_reg[MODIFIED_BIT] && bus_fault_out)
    else $error("modified-line violation not raised");
  missing_confirm_a: assert property (missing_confirm_err |=>
      flags_reg[MISSING_CONFIRM_BIT] && bus_fault_out)
    else $error("missing confirmation not raised");
  driving_fault_a: assert property (driving_data && uncorrectable_err |=>
      flags_reg[DRIVING_FAULT_BIT] && bus_fault_out)
    else $error("fault while driving not raised");
  reg_parity_a: assert property (register_parity_err && flags_reg[REG_PARITY_BIT] |=>
      flags_reg[REG_PARITY2_BIT])
    else $error("second register parity flag missing");
  cmd_parity_a: assert property (command_parity_err && !flags_reg[CMD_PARITY_BIT] |=>
      flags_reg[CMD_PARITY_BIT] && bus_fault_out)
    else $error("command parity flag not raised");
  second_corr_a: assert property (corr_seen && flags_reg[CORR_BIT] |=>
      flags_reg[CORR2_BIT])
    else $error("second correctable flag missing");
  capture_lock_a: assert property (uncorrectable_err && !(|(flags_reg & CAPTURE_MASK)) |=>
      captured_command == $past(command_bits))
    else $error("command bits not captured");
  selftest_clear_a: assert property (selftest_done && !bus_reset_cmd |=>
      !selftest_reg)
    else $error("self-test pending not cleared");
  corr_gate_a: assert property (!corr_en_reg |=> !$rose(flags_reg[CORR_BIT]))
    else $error("correctable flag set while disabled");
  fault_seen_a: assert property ($rose(bus_fault_in) ##2 sync_reg |=>
      flags_reg[FAULT_SEEN_BIT])
    else $error("fault line not recorded");
  reinit_join_a: assert property (wr_config && avs_writedata[REINIT_BIT] |=>
      node_reinit && console_mode && join_reg ##1 !node_reinit)
    else $error("reinit trigger effects wrong");
  join_keep_a: assert property (join_reg && !bus_reset_cmd &&
      !(wr_config && avs_writedata[JOIN_BIT]) |=> join_reg)
    else $error("join flag lost without clear");
  halt_console_a: assert property (halt_reg |-> console_mode)
    else $error("halt without console mode");
  fault_line_a: assert property (|(flags_reg & FAULT_LINE_MASK) |-> bus_fault_out)
    else $error("fault line released early");
  answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
    else $error("bus request not answered");

endmodule // bec_regs

// ==== dv/bec_bus_node.sv ====
`timescale 1ns/1ps
module bec_bus_node (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [11:0] req,
  input wire logic [38:0] cmd_in,
  input wire logic drv_in,
  input wire logic ext_fault,
  input wire logic node_fault,
  output logic [11:0] errs,
  output logic [38:0] cmd_out,
  output logic drv_out,
  output logic fault_line
);
  // ****
  // Event lines of the other nodes
  // ****
  logic [11:0] errs_next;
  logic [38:0] cmd_next;
  logic drv_next;
  logic ext_reg;
  logic ext_next;

  always_comb begin
    errs_next = req;
    cmd_next = cmd_in;
    drv_next = drv_in;
    ext_next = ext_fault;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      errs <= '0;
      cmd_out <= '0;
      drv_out <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      errs <= errs_next;
      cmd_out <= cmd_next;
      drv_out <= drv_next;
      ext_reg <= ext_next;
    end
  end

  assign fault_line = ext_reg | node_fault;
endmodule // bec_bus_node

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import bec_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] req = '0;
  logic [38:0] cmd_in = '0;
  logic drv_in = 1'b0;
  logic ext_fault = 1'b0;
  logic module_fault = 1'b0;
  logic selftest_done = 1'b0;
  logic bus_reset_cmd = 1'b0;
  logic [11:0] errs;
  logic [38:0] command_bits;
  logic [38:0] captured_command;
  logic driving_data;
  logic bus_fault_in;
  logic bus_fault_out;
  logic console_mode;
  logic node_reinit;
  logic correctable_detect_on;
  logic [31:0] lfsr_state = 32'h93db2f7a;
  logic [31:0] rdata;
  logic [31:0] flags;
  int n_fail = 0;
  int checks = 0;
  int n_reinit = 0;
  int ebit [12] = '{17, 16, 15, 14, 13, 12, 11, 10, 3, 1, 5, 7};

  always #10 clock = ~clock;
  always @(posedge clock) if (node_reinit === 1'b1) n_reinit <= n_reinit + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  bec_bus_node partner (.clock(clock), .arst_n(arst_n), .req(req), .cmd_in(cmd_in),
    .drv_in(drv_in), .ext_fault(ext_fault), .node_fault(bus_fault_out), .errs(errs),
    .cmd_out(command_bits), .drv_out(driving_data), .fault_line(bus_fault_in));

  bec_regs dut (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctl_drive_err(errs[0]), .data_drive_err(errs[1]),
    .modified_signal_err(errs[2]), .copy_held_err(errs[3]), .command_strobe_err(errs[4]),
    .missing_confirm_err(errs[5]), .unexpected_confirm_err(errs[6]),
    .hold_off_err(errs[7]), .correctable_err(errs[8]), .uncorrectable_err(errs[9]),
    .command_parity_err(errs[10]), .register_parity_err(errs[11]),
    .driving_data(driving_data), .command_bits(command_bits), .module_fault(module_fault),
    .bus_fault_in(bus_fault_in), .selftest_done(selftest_done),
    .bus_reset_cmd(bus_reset_cmd), .bus_fault_out(bus_fault_out),
    .captured_command(captured_command), .console_mode(console_mode),
    .node_reinit(node_reinit), .correctable_detect_on(correctable_detect_on));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: register %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [38:0] got, input logic [38:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: output %h want %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; waitrequest and read data are taken at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_fail++;
        $display("unexpected at %0t: no bus answer", $time);
        end_of_test();
      end
      @(posedge clock);
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, FULL_WORD_BE);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, FULL_WORD_BE);
    chk_reg(rdata, exp);
  endtask

  task automatic fire(input logic [11:0] v, input logic drv);
    cmd_in <= {lfsr_state[6:0], lfsr_state};
    lfsr_state = lfsr(lfsr_state);
    req <= v;
    drv_in <= drv;
    @(posedge clock);
    req <= '0;
    @(posedge clock);
  endtask

  // One-cycle pulse: 0 fault line, 1 bus reset, other self-test done
  task automatic pulse(input int which);
    case (which)
      0: ext_fault <= 1'b1;
      1: bus_reset_cmd <= 1'b1;
      default: selftest_done <= 1'b1;
    endcase
    @(posedge clock);
    ext_fault <= 1'b0;
    bus_reset_cmd <= 1'b0;
    selftest_done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    int i;
    int b;
    logic two;
    logic [38:0] cap;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(BUS_FAULT_OFS, 32'h0);
    rd(NODE_CONFIG_OFS, 32'h80000000);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 32'h0);
    fire(12'h100, 1'b0);
    rd(BUS_FAULT_OFS, 32'h0);
    wr(NODE_CONFIG_OFS, 32'h1);
    chk_out(correctable_detect_on, 39'h1);
    $display("test reset_and_enable done");
    for (i = 0; i < 12; i++) begin
      b = ebit[i];
      two = (i >= 8);
      fire(12'h1 << i, two);
      cap = cmd_in;
      flags = (32'h1 << b) | 32'h1 | (two ? ((32'h1 << (b + 1)) | 32'h200) : 32'h0);
      if (two) fire(12'h1 << i, 1'b1);
      repeat (5) @(posedge clock);
      chk_out(bus_fault_out, 39'h1);
      rd(BUS_FAULT_OFS, flags);
      if (two) chk_out(captured_command, cap);
      wr(BUS_FAULT_OFS, 32'h0);
      rd(BUS_FAULT_OFS, flags);
      wr(BUS_FAULT_OFS, 32'h3ffff);
      repeat (6) @(posedge clock);
      wr(BUS_FAULT_OFS, 32'h3ffff);
      rd(BUS_FAULT_OFS, 32'h0);
      chk_out(bus_fault_out, 39'h0);
    end
    $display("test fault_flags done");
    module_fault <= 1'b1;
    repeat (3) @(posedge clock);
    rd(BUS_FAULT_OFS, 32'h40000);
    wr(BUS_FAULT_OFS, 32'h40000);
    rd(BUS_FAULT_OFS, 32'h40000);
    module_fault <= 1'b0;
    repeat (3) @(posedge clock);
    rd(BUS_FAULT_OFS, 32'h0);
    pulse(0);
    repeat (3) @(posedge clock);
    rd(BUS_FAULT_OFS, 32'h1);
    chk_out(bus_fault_out, 39'h0);
    wr(BUS_FAULT_OFS, 32'h1);
    rd(BUS_FAULT_OFS, 32'h0);
    $display("test summary_and_line done");
    wr(NODE_CONFIG_OFS, 32'h20000001);
    chk_out(console_mode, 39'h1);
    wr(NODE_CONFIG_OFS, 32'h60000001);
    @(posedge clock);
    chk_out(39'(n_reinit), 39'h1);
    rd(NODE_CONFIG_OFS, 32'hb0000001);
    bus(1'b1, NODE_CONFIG_OFS, 32'h0, 4'h3);
    rd(NODE_CONFIG_OFS, 32'hb0000001);
    wr(NODE_CONFIG_OFS, 32'h30000001);
    rd(NODE_CONFIG_OFS, 32'ha0000001);
    wr(NODE_CONFIG_OFS, 32'h80000001);
    rd(NODE_CONFIG_OFS, 32'h00000001);
    chk_out(console_mode, 39'h0);
    wr(NODE_CONFIG_OFS, 32'h40000001);
    rd(NODE_CONFIG_OFS, 32'h10000001);
    pulse(1);
    rd(NODE_CONFIG_OFS, 32'h80000000);
    chk_out(correctable_detect_on, 39'h0);
    pulse(2);
    rd(NODE_CONFIG_OFS, 32'h0);
    chk_out(39'(n_reinit), 39'h2);
    $display("test node_config done");
    end_of_test();
  end
endmodule // testbench
